// ### core/bbs_exec.v
`timescale 1ns/1ns
`include "bbs_regs.vh"
module bbs_exec #(
  parameter AW  = 12,             // Data address width
  parameter PCW = 21              // Program counter width
) (
  input  wire           clk,        // Core clock, one phase per edge
  input  wire           reset_n,    // Async reset, active low
  input  wire           clkEn,      // Freezes all state while low
  input  wire [15:0]    instrWord,  // Instruction latched at fetch
  input  wire           instrValid, // Instruction word is meaningful
  input  wire           nextIsTwoWord, // Prefetched word is 2-word op
  input  wire [PCW-1:0] pcIn,       // Already incremented PC
  input  wire           negFlag,    // Negative status flag
  input  wire           extEnable,  // Extended instruction set on
  input  wire [3:0]     bankSelect, // Bank select register
  input  wire [AW-1:0]  indexBase,  // Index pointer base
  input  wire [7:0]     dataRd,     // Data memory read value
  output reg  [1:0]     phase,      // Current phase Q1..Q4
  output reg            cycleEnd,   // Last phase of an instr cycle
  output reg  [AW-1:0]  dataAddr,   // Data memory address
  output reg            dataRdEn,   // Read strobe in Q2
  output reg            dataWrEn,   // Write strobe in Q4
  output reg  [7:0]     dataWr,     // Data to write
  output reg            wregWrEn,   // Working register write strobe
  output reg  [7:0]     wregWr,     // Working register value
  output reg            pcWrEn,     // PC load strobe in Q4
  output reg  [PCW-1:0] pcWr,       // New PC value
  output reg            flush,      // Discard prefetched instruction
  output reg            busy        // Executing inserted idle cycles
);
  // Cycle states, one-hot
  localparam [2:0] ST_EXEC  = 3'b001;
  localparam [2:0] ST_NOP1  = 3'b010;
  localparam [2:0] ST_NOP2  = 3'b100;

  reg  [2:0]    state;
  reg  [2:0]    next_state;
  reg  [7:0]    opData;
  wire [AW-1:0] resolvedAddr;
  wire          usesIndex;

  // Opcode decode
  wire isBitClr  = instrValid && (instrWord[15:12] == `BBS_OPC_BITCLR);
  wire isBrNeg   = instrValid && (instrWord[15:8] == `BBS_OPC_BRNEG);
  wire isDecSkZ  = instrValid && (instrWord[15:10] == `BBS_OPC_DECSKZ);
  wire isDecSkNZ = instrValid && (instrWord[15:10] == `BBS_OPC_DECSKNZ);
  wire isDec     = isDecSkZ || isDecSkNZ;
  wire toFile    = instrWord[`BBS_DEST_BIT];
  wire [2:0] bitPos = instrWord[`BBS_BIT_MSB:`BBS_BIT_LSB];

  bbs_addr_gen #(.AW(AW)) addrGen (
    .fileOp     (instrWord[7:0]),
    .accSel     (instrWord[`BBS_ACC_BIT]),
    .extEnable  (extEnable),
    .bankSelect (bankSelect),
    .indexBase  (indexBase),
    .dataAddr   (resolvedAddr),
    .indexed    (usesIndex)
  );

  // Data path results, computed from the value captured in Q2
  wire [7:0] decResult = opData - 8'h01;
  wire [7:0] clrResult = opData & ~(8'h01 << bitPos);
  wire skipNow = (isDecSkZ && (decResult == 8'h00)) ||
                 (isDecSkNZ && (decResult != 8'h00));
  wire brTaken = isBrNeg && negFlag;
  wire [PCW-1:0] brOffset = {{(PCW-9){instrWord[7]}}, instrWord[7:0], 1'b0};

  // Next cycle state, evaluated at the end of Q4
  always @* begin
    next_state = state;
    case (state)
      ST_EXEC: begin
        // Taken branch adds one idle cycle
        if (brTaken)
          next_state = ST_NOP1;
        // Skip over one or two words
        else if (skipNow)
          next_state = nextIsTwoWord ? ST_NOP2 : ST_NOP1;
      end
      ST_NOP2: next_state = ST_NOP1;
      ST_NOP1: next_state = ST_EXEC;
      default: next_state = ST_EXEC;
    endcase
  end

  // Phase counter and cycle state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= `BBS_Q1;
      state <= ST_EXEC;
    end else if (clkEn) begin
      phase <= phase + 2'h1;
      if (phase == `BBS_Q4)
        state <= next_state;
    end
  end

  // Capture operand in Q2 so Q3/Q4 see a stable value
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      opData <= 8'h00;
    else if (clkEn && (state == ST_EXEC) && (phase == `BBS_Q2))
      opData <= dataRd;
  end

  // Registered outputs; strobes last one phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycleEnd <= 1'b0;
      dataAddr <= {AW{1'b0}};
      dataRdEn <= 1'b0;
      dataWrEn <= 1'b0;
      dataWr   <= 8'h00;
      wregWrEn <= 1'b0;
      wregWr   <= 8'h00;
      pcWrEn   <= 1'b0;
      pcWr     <= {PCW{1'b0}};
      flush    <= 1'b0;
      busy     <= 1'b0;
    end else if (clkEn) begin
      cycleEnd <= (phase == `BBS_Q3);
      dataRdEn <= 1'b0;
      dataWrEn <= 1'b0;
      wregWrEn <= 1'b0;
      pcWrEn   <= 1'b0;
      flush    <= 1'b0;
      busy     <= (state != ST_EXEC);
      if (state == ST_EXEC) begin
        dataAddr <= resolvedAddr;
        // Read strobe lands in Q2
        if (phase == `BBS_Q1)
          dataRdEn <= isBitClr || isDec;
        // Writes land in Q4; status flags never touched here
        if (phase == `BBS_Q3) begin
          if (isBitClr) begin
            dataWrEn <= 1'b1;
            dataWr   <= clrResult;
          end
          if (isDec) begin
            dataWrEn <= toFile;
            wregWrEn <= ~toFile;
            dataWr   <= decResult;
            wregWr   <= decResult;
          end
          // No PC write when not taken
          if (brTaken) begin
            pcWrEn <= 1'b1;
            pcWr   <= pcIn + brOffset;
          end
          flush <= brTaken || skipNow;
        end
      end
    end
  end

  // Index mode is visible only through the resolved address
  wire unusedIndex = usesIndex;
endmodule // bbs_exec

// ### shared/bbs_regs.vh
`ifndef BBS_REGS_VH
`define BBS_REGS_VH
// Opcode patterns, matched against the top bits of the instruction word
`define BBS_OPC_BITCLR    4'h9
`define BBS_OPC_BRNEG     8'hE6
`define BBS_OPC_DECSKZ    6'h0B
`define BBS_OPC_DECSKNZ   6'h13
// Field positions
`define BBS_BIT_MSB       11
`define BBS_BIT_LSB       9
`define BBS_DEST_BIT      9
`define BBS_ACC_BIT       8
// Access bank split: operands at or below this go to the low bank, or to the index pointer plus offset in extended mode
`define BBS_ACC_SPLIT     8'h5F
`define BBS_ACC_HIBANK    4'hF
// Phase codes inside one instruction cycle
`define BBS_Q1            2'h0
`define BBS_Q2            2'h1
`define BBS_Q3            2'h2
`define BBS_Q4            2'h3
`endif

// ### core/bbs_addr_gen.v
`timescale 1ns/1ns
`include "bbs_regs.vh"
// Data address resolution shared by all file-register operations
module bbs_addr_gen #(
  parameter AW = 12               // Data address width
) (
  input  wire [7:0]    fileOp,     // Register operand
  input  wire          accSel,     // Bank-select operand bit
  input  wire          extEnable,  // Extended instruction set enabled
  input  wire [3:0]    bankSelect, // Bank select register contents
  input  wire [AW-1:0] indexBase,  // Index pointer for literal offsets
  output reg  [AW-1:0] dataAddr,   // Resolved data address
  output reg           indexed     // Literal offset mode in use
);
  // Operand resolution by bank-select bit and extended mode
  always @* begin
    indexed  = 1'b0;
    dataAddr = {AW{1'b0}};
    if (accSel) begin
      // Banked GENERAL_PURPOSE_REGISTER access; upper bits stay zero when AW is wider
      dataAddr[11:0] = {bankSelect, fileOp};
    end else if (extEnable && (fileOp <= `BBS_ACC_SPLIT)) begin
      indexed  = 1'b1;
      dataAddr = indexBase + {{(AW-8){1'b0}}, fileOp};
    end else begin
      if (fileOp <= `BBS_ACC_SPLIT)
        dataAddr[11:0] = {4'h0, fileOp};
      else
        dataAddr[11:0] = {`BBS_ACC_HIBANK, fileOp};
    end
  end
endmodule // bbs_addr_gen

// ### verification/bbs_exec_props.sv
`timescale 1ns/1ns
// Watches the execution block at its ports only
module bbs_exec_props (
  input wire        clk,        // Core clock
  input wire        reset_n,    // Async reset
  input wire [15:0] instrWord,  // Instruction
  input wire [20:0] pcIn,       // Incremented PC
  input wire        negFlag,    // N flag
  input wire [3:0]  bankSelect, // Bank select
  input wire [1:0]  phase,      // Q phase
  input wire [11:0] dataAddr,   // Data address
  input wire        dataRdEn,   // Read strobe
  input wire        dataWrEn,   // Write strobe
  input wire [7:0]  dataWr,     // Write data
  input wire        pcWrEn,     // PC load
  input wire [20:0] pcWr,       // New PC
  input wire        flush,      // Discard prefetch
  input wire        busy        // Idle cycles
);
  // One clock domain, so one clocking and one reset for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_phase: assert property (dataRdEn |-> phase == 2'h1)
    else $error("read strobe outside Q2");
  a_write_phase: assert property (dataWrEn |-> phase == 2'h3)
    else $error("write strobe outside Q4");
  a_clear_bit: assert property (dataWrEn && instrWord[15:12] == 4'h9
    |-> !dataWr[instrWord[11:9]]) else $error("cleared bit still set");
  a_bank_addr: assert property (dataRdEn && instrWord[8]
    |-> dataAddr == {bankSelect, instrWord[7:0]}) else $error("bad bank");
  a_high_access: assert property (dataRdEn && !instrWord[8]
    && instrWord[7:0] > 8'h5F |-> dataAddr == {4'hF, instrWord[7:0]})
    else $error("bad access bank address");
  a_taken_neg: assert property (pcWrEn |-> negFlag
    && instrWord[15:8] == 8'hE6) else $error("branch without N set");
  a_pc_target: assert property (pcWrEn |-> pcWr == pcIn
    + {{12{instrWord[7]}}, instrWord[7:0], 1'b0}) else $error("bad target");
  a_pc_flush: assert property (pcWrEn |-> flush && phase == 2'h3)
    else $error("taken branch without flush in Q4");
  a_flush_idle: assert property (flush |-> ##3 busy)
    else $error("no idle cycle after flush");
endmodule // bbs_exec_props

bind bbs_exec bbs_exec_props uProps (.clk(clk), .reset_n(reset_n),
  .instrWord(instrWord), .pcIn(pcIn), .negFlag(negFlag),
  .bankSelect(bankSelect), .phase(phase), .dataAddr(dataAddr),
  .dataRdEn(dataRdEn), .dataWrEn(dataWrEn), .dataWr(dataWr),
  .pcWrEn(pcWrEn), .pcWr(pcWr), .flush(flush), .busy(busy));

// ### verification/bit_branch_skip_instr_exec_bench.sv
`timescale 1ns/1ns
// Self-checking bench for the execution block
module bit_branch_skip_instr_exec_bench;
  logic        clk, reset_n, instrValid, nextIsTwoWord, negFlag, extEnable;
  logic        cycleEnd, dataRdEn, dataWrEn, wregWrEn, pcWrEn, flush, busy;
  logic [15:0] instrWord;
  logic [20:0] pcIn, pcWr;
  logic [11:0] indexBase, dataAddr;
  logic [7:0]  dataRd, dataWr, wregWr;
  logic [3:0]  bankSelect;
  logic [1:0]  phase;
  integer      err_total = 0, samples_checked = 0, b;
  bbs_exec DUT (.clk(clk), .reset_n(reset_n), .clkEn(1'b1),
    .instrWord(instrWord), .instrValid(instrValid), .pcIn(pcIn),
    .nextIsTwoWord(nextIsTwoWord), .negFlag(negFlag), .dataRd(dataRd),
    .extEnable(extEnable), .bankSelect(bankSelect), .indexBase(indexBase),
    .phase(phase), .cycleEnd(cycleEnd), .dataAddr(dataAddr),
    .dataRdEn(dataRdEn), .dataWrEn(dataWrEn), .dataWr(dataWr),
    .wregWrEn(wregWrEn), .wregWr(wregWr), .pcWrEn(pcWrEn), .pcWr(pcWr),
    .flush(flush), .busy(busy));
  // Clock of 50 ns
  always #25 clk = ~clk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for a free Q1, holds the word, returns in its Q4
  task exec(input logic [15:0] w);
    for (int i = 0; i < 40 && (phase !== 2'h0 || busy !== 1'b0); i++) begin
      @(posedge clk);
      #1;
    end
    instrWord = w;
    instrValid = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Busy is looked at mid-cycle, away from its one phase lag
  task fin(input integer k);
    @(posedge clk);
    #1;
    instrValid = 1'b0;
    for (int j = 0; j <= k; j++) begin
      repeat (j == 0 ? 2 : 4) @(posedge clk);
      #1;
      chk(busy, j < k);
    end
  endtask
  task t_bitclr;
    dataRd = 8'hFF;
    for (b = 0; b < 8; b++) begin
      exec({4'h9, b[2:0], 1'b1, 8'h42});
      chk(dataWr, 8'hFF ^ (8'h01 << b));
      chk(dataAddr, 12'h342);
      chk({cycleEnd, dataWrEn, phase}, 4'hF);
      fin(0);
    end
  endtask
  // Split point of the access bank with the extension on
  task t_access;
    extEnable = 1'b1;
    exec(16'h90A0);
    chk(dataAddr, 12'hFA0);
    fin(0);
    exec(16'h905F);
    chk(dataAddr, 12'h15F);
    fin(0);
    extEnable = 1'b0;
  endtask
  task t_branch;
    exec(16'hE680);
    chk(pcWrEn, 1'b0);
    fin(0);
    negFlag = 1'b1;
    exec(16'hE680);
    chk(pcWr, 21'h000000);
    chk({pcWrEn, flush}, 2'h3);
    fin(1);
    exec(16'hE67F);
    chk(pcWr, 21'h0001FE);
    fin(1);
    negFlag = 1'b0;
  endtask
  task t_skip;
    dataRd = 8'h01;
    exec(16'h2F10);
    chk(dataWr, 8'h00);
    fin(1);
    nextIsTwoWord = 1'b1;
    exec(16'h2F10);
    fin(2);
    dataRd = 8'h05;
    exec(16'h2D10);
    chk({wregWrEn, wregWr}, 9'h104);
    fin(0);
    exec(16'h4F10);
    chk(dataWr, 8'h04);
    fin(2);
    dataRd = 8'h01;
    exec(16'h4F10);
    fin(0);
  endtask
  task final_report;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole run needs about 185 cycles
  initial begin
    #400000;
    err_total++;
    final_report;
  end
  initial begin
    {clk, reset_n, instrValid, nextIsTwoWord, negFlag, extEnable} = 6'h00;
    {instrWord, dataRd} = {16'h0000, 8'h00};
    {pcIn, indexBase} = {21'h000100, 12'h100};
    bankSelect = 4'h3;
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_bitclr;
    t_access;
    t_branch;
    t_skip;
    final_report;
  end
endmodule // bit_branch_skip_instr_exec_bench
